// [core/mbs_decode.v]
// decode array: each select is the OR of its product terms
// assumes term words are held in flip-flops by the caller
`timescale 1ns/1ps
`include "mbs_defs.vh"
module mbs_decode #(
    parameter NUM_SEL = 21,
    parameter NTERM   = 3
) (
    input  wire [NUM_SEL*NTERM*`MBS_TERM_W-1:0] terms_i,
    input  wire [7:0]                           addr_hi_i,
    input  wire                                 prog_space_i,
    input  wire                                 strobe_i,
    output wire [NUM_SEL-1:0]                   sel_o
);
    wire [NUM_SEL*NTERM-1:0] hit;
    genvar g;
    generate
        for (g = 0; g < NUM_SEL*NTERM; g = g + 1)
        begin : g_term
            wire [`MBS_TERM_W-1:0] t;
            wire [7:0]             mt;
            wire [7:0]             cr;
            wire                   sp;
            assign t  = terms_i[g*`MBS_TERM_W +: `MBS_TERM_W];
            assign mt = t[`MBS_TERM_MATCH_LSB +: 8];
            assign cr = t[`MBS_TERM_CARE_LSB +: 8];
            // space qualifier lets a sector move between spaces
            assign sp = prog_space_i ? t[`MBS_TERM_PROG] : t[`MBS_TERM_DATA];
            assign hit[g] = strobe_i & t[`MBS_TERM_EN] & sp
                            & (((addr_hi_i ^ mt) & cr) == 8'h00);
        end
        for (g = 0; g < NUM_SEL; g = g + 1)
        begin : g_sel
            assign sel_o[g] = |hit[g*NTERM +: NTERM];
        end
    endgenerate
endmodule // mbs_decode

// [core/mbs_defs.vh]
// constants of the memory block select and id logic
// assumes a 32-bit classic wishbone slave at 100 MHz
// How it works
// - primary flash size code in id0 low nibble
// - sram size code in id0 high nibble
// - secondary memory size code in id1 low nibble
// - secondary type in id1 bits 5:4, 7:6 zero
// - sixteen 64K primary sectors, one select each
// - four secondary sectors 16K 8K 8K 32K, selects
// - one 32K sram region with one select
// - every select comes from the decode array
// - each select is OR of three product terms
// - terms qualify program or data space for remapping
// - each sector protected from program/erase separately
// - erase one sector, program one word, at a time
// - sector erase may suspend, reads, then resume
// - ready/busy low while programming or erasing
// - ready/busy high when no cycle runs
`ifndef MBS_DEFS_VH
`define MBS_DEFS_VH
`define MBS_ADR_ID0       8'h00
`define MBS_ADR_ID1       8'h04
`define MBS_ADR_CMD       8'h08
`define MBS_ADR_STATUS    8'h0c
`define MBS_ADR_PROT      8'h10
`define MBS_ADR_IRQ_STAT  8'h14
`define MBS_ADR_IRQ_MASK  8'h18
`define MBS_ADR_TERM_IDX  8'h1c
`define MBS_ADR_TERM_DATA 8'h20
// size codes and secondary type
`define MBS_PRIM_SIZE     4'h6
`define MBS_SRAM_SIZE     4'h5
`define MBS_SEC_SIZE      4'h3
`define MBS_SEC_TYPE      2'h0
// command register fields
`define MBS_CMD_OP_LSB    0
`define MBS_CMD_SEC_LSB   4
`define MBS_OP_PROG       3'h1
`define MBS_OP_ERASE      3'h2
`define MBS_OP_SUSPEND    3'h3
`define MBS_OP_RESUME     3'h4
// interrupt bits
`define MBS_IRQ_DONE      0
`define MBS_IRQ_PROT      1
`define MBS_IRQ_REJECT    2
// product term fields
`define MBS_TERM_MATCH_LSB 0
`define MBS_TERM_CARE_LSB  8
`define MBS_TERM_EN        16
`define MBS_TERM_PROG      17
`define MBS_TERM_DATA      18
`define MBS_TERM_W         19
// counts of selects and terms
`define MBS_NUM_PRIM      16
`define MBS_NUM_SEC       4
`define MBS_NUM_SEL       21
`define MBS_TERMS_PER_SEL 3
// timing
`define MBS_CLK_NS        10
`define MBS_PROG_TIME_NS  10000
`define MBS_ERASE_TIME_NS 1000000
`define MBS_PROG_CYCLES   (`MBS_PROG_TIME_NS / `MBS_CLK_NS)
`define MBS_ERASE_CYCLES  (`MBS_ERASE_TIME_NS / `MBS_CLK_NS)
`endif

// [core/mbs_top.v]
// memory block select, id registers and flash busy sequencer
// assumes classic wishbone master and synchronous mcu inputs
//
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "mbs_defs.vh"
module mbs_top #(
    parameter PROG_CYCLES  = `MBS_PROG_CYCLES,
    parameter ERASE_CYCLES = `MBS_ERASE_CYCLES,
    parameter ADDR_W       = 24
) (
    input  wire              clk_i,
    input  wire              rst_i,
    input  wire              wb_cyc_i,
    input  wire              wb_stb_i,
    input  wire              wb_we_i,
    input  wire [7:0]        wb_adr_i,
    input  wire [3:0]        wb_sel_i,
    input  wire [31:0]       wb_dat_i,
    output wire [31:0]       wb_dat_o,
    output wire              wb_ack_o,
    input  wire [ADDR_W-1:0] mcu_addr_i,
    input  wire              mcu_prog_space_i,
    input  wire              mcu_strobe_i,
    output wire [15:0]       primary_sector_selects_o,
    output wire [3:0]        secondary_sector_selects_o,
    output wire              sram_select_o,
    output wire              ready_busy_output_o,
    output wire              irq_o
);
    localparam NSEL  = `MBS_NUM_SEL;
    localparam NTERM = NSEL * `MBS_TERMS_PER_SEL;
    localparam TW    = `MBS_TERM_W;

    localparam ST_IDLE    = 2'd0;
    localparam ST_PROG    = 2'd1;
    localparam ST_ERASE   = 2'd2;
    localparam ST_SUSPEND = 2'd3;

    // counts are cut to the width of the 24-bit down counter
    localparam [23:0] PROG_CNT  = PROG_CYCLES[23:0];
    localparam [23:0] ERASE_CNT = ERASE_CYCLES[23:0];

    reg  [31:0]   dat_reg;
    reg  [31:0]   dat_next;
    reg           ack_reg;
    reg  [1:0]    state_reg;
    reg  [1:0]    state_next;
    reg  [23:0]   cnt_reg;
    reg  [23:0]   cnt_next;
    reg  [4:0]    sector_reg;
    reg  [4:0]    sector_next;
    reg  [19:0]   prot_reg;
    reg  [2:0]    stat_reg;
    reg  [2:0]    stat_next;
    reg  [2:0]    mask_reg;
    reg  [5:0]    idx_reg;
    reg  [TW-1:0] term_mem [0:NTERM-1];
    reg  [NSEL-1:0] sel_reg;
    reg           rb_reg;
    reg           irq_reg;
    reg  [2:0]    evt;

    wire          req;
    wire          wr;
    wire          rd;
    wire [31:0]   wmask;
    wire [2:0]    cmd_op;
    wire [4:0]    cmd_sec;
    wire          cmd_wr;
    wire [NTERM*TW-1:0] terms_flat;
    wire [NSEL-1:0]     sel_comb;
    wire [7:0]    id0;
    wire [7:0]    id1;

    // one request is served per ack; ack drops the cycle after
    assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr  = req & wb_we_i;
    assign rd  = req & ~wb_we_i;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    assign id0 = {`MBS_SRAM_SIZE, `MBS_PRIM_SIZE};
    assign id1 = {2'h0, `MBS_SEC_TYPE, `MBS_SEC_SIZE};

    assign cmd_wr  = wr & (wb_adr_i == `MBS_ADR_CMD) & wb_sel_i[0];
    assign cmd_op  = wb_dat_i[`MBS_CMD_OP_LSB +: 3];
    assign cmd_sec = wb_dat_i[`MBS_CMD_SEC_LSB +: 5];

    // read mux
    always @*
    begin
        dat_next = 32'h0000_0000;
        case (wb_adr_i)
            `MBS_ADR_ID0:       dat_next = {24'h00_0000, id0};
            `MBS_ADR_ID1:       dat_next = {24'h00_0000, id1};
            `MBS_ADR_STATUS:    dat_next = {24'h00_0000, sector_reg,
                                            (state_reg == ST_SUSPEND),
                                            (state_reg == ST_PROG) |
                                            (state_reg == ST_ERASE),
                                            rb_reg};
            `MBS_ADR_PROT:      dat_next = {12'h000, prot_reg};
            `MBS_ADR_IRQ_STAT:  dat_next = {29'h0000_0000, stat_reg};
            `MBS_ADR_IRQ_MASK:  dat_next = {29'h0000_0000, mask_reg};
            `MBS_ADR_TERM_IDX:  dat_next = {26'h000_0000, idx_reg};
            `MBS_ADR_TERM_DATA: dat_next = {{(32-TW){1'b0}}, term_mem[idx_reg]};
            default:            dat_next = 32'h0000_0000;
        endcase
    end

    // wishbone answer
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end
        else
        begin
            ack_reg <= req;
            if (rd)
            begin
                dat_reg <= dat_next;
            end
        end
    end

    // sequencer for program, erase, suspend and resume
    always @*
    begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        sector_next = sector_reg;
        evt         = 3'h0;
        case (state_reg)
            ST_IDLE:
            begin
                if (cmd_wr)
                begin
                    if ((cmd_op == `MBS_OP_PROG) || (cmd_op == `MBS_OP_ERASE))
                    begin
                        // sectors 20 and up do not exist
                        if (cmd_sec >= 5'd20)
                        begin
                            evt[`MBS_IRQ_REJECT] = 1'b1;
                        end
                        else if (prot_reg[cmd_sec])
                        begin
                            evt[`MBS_IRQ_PROT] = 1'b1;
                        end
                        else
                        begin
                            // a single word or a single sector per command
                            sector_next = cmd_sec;
                            if (cmd_op == `MBS_OP_PROG)
                            begin
                                state_next = ST_PROG;
                                cnt_next   = PROG_CNT;
                            end
                            else
                            begin
                                state_next = ST_ERASE;
                                cnt_next   = ERASE_CNT;
                            end
                        end
                    end
                    else
                    begin
                        evt[`MBS_IRQ_REJECT] = 1'b1;
                    end
                end
            end
            ST_PROG, ST_ERASE:
            begin
                // only an erase may be suspended
                if (cmd_wr && (state_reg == ST_ERASE) &&
                    (cmd_op == `MBS_OP_SUSPEND))
                begin
                    state_next = ST_SUSPEND;
                end
                else
                begin
                    if (cmd_wr)
                    begin
                        evt[`MBS_IRQ_REJECT] = 1'b1;
                    end
                    if (cnt_reg <= 24'd1)
                    begin
                        state_next = ST_IDLE;
                        cnt_next   = 24'd0;
                        evt[`MBS_IRQ_DONE] = 1'b1;
                    end
                    else
                    begin
                        cnt_next = cnt_reg - 24'd1;
                    end
                end
            end
            ST_SUSPEND:
            begin
                // count is held so resume finishes the remaining erase
                if (cmd_wr)
                begin
                    if (cmd_op == `MBS_OP_RESUME)
                    begin
                        state_next = ST_ERASE;
                    end
                    else
                    begin
                        evt[`MBS_IRQ_REJECT] = 1'b1;
                    end
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @*
    begin
        stat_next = stat_reg;
        if (wr && (wb_adr_i == `MBS_ADR_IRQ_STAT) && wb_sel_i[0])
        begin
            stat_next = stat_reg & ~wb_dat_i[2:0];
        end
        // a new event wins over a clear in the same cycle
        stat_next = stat_next | evt;
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg  <= ST_IDLE;
            cnt_reg    <= 24'd0;
            sector_reg <= 5'd0;
            stat_reg   <= 3'h0;
            irq_reg    <= 1'b0;
            rb_reg     <= 1'b1;
        end
        else
        begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            sector_reg <= sector_next;
            stat_reg   <= stat_next;
            irq_reg    <= |(stat_next & mask_reg);
            // busy low while a program or erase runs
            rb_reg     <= ~((state_next == ST_PROG) ||
                            (state_next == ST_ERASE));
        end
    end

    // software registers; id addresses take no write
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prot_reg <= 20'h0_0000;
            mask_reg <= 3'h0;
            idx_reg  <= 6'h00;
        end
        else if (wr)
        begin
            case (wb_adr_i)
                `MBS_ADR_PROT:
                    prot_reg <= (prot_reg & ~wmask[19:0]) |
                                (wb_dat_i[19:0] & wmask[19:0]);
                `MBS_ADR_IRQ_MASK:
                    if (wb_sel_i[0])
                    begin
                        mask_reg <= wb_dat_i[2:0];
                    end
                `MBS_ADR_TERM_IDX:
                    if (wb_sel_i[0] && (wb_dat_i[5:0] < 6'd63))
                    begin
                        idx_reg <= wb_dat_i[5:0];
                    end
                `MBS_ADR_ID0, `MBS_ADR_ID1:
                begin
                    // id words are constants, a write changes nothing
                    idx_reg <= idx_reg;
                end
                default:
                    idx_reg <= idx_reg;
            endcase
        end
    end

    // product term storage written through index and data window
    genvar g;
    generate
        for (g = 0; g < NTERM; g = g + 1)
        begin : g_mem
            always @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    term_mem[g] <= {TW{1'b0}};
                end
                else if (wr && (wb_adr_i == `MBS_ADR_TERM_DATA) &&
                         (idx_reg == g))
                begin
                    term_mem[g] <= (term_mem[g] & ~wmask[TW-1:0]) |
                                   (wb_dat_i[TW-1:0] & wmask[TW-1:0]);
                end
            end
            assign terms_flat[g*TW +: TW] = term_mem[g];
        end
    endgenerate

    mbs_decode #(
        .NUM_SEL (NSEL),
        .NTERM   (`MBS_TERMS_PER_SEL)
    ) u_decode (
        .terms_i      (terms_flat),
        .addr_hi_i    (mcu_addr_i[ADDR_W-1 -: 8]),
        .prog_space_i (mcu_prog_space_i),
        .strobe_i     (mcu_strobe_i),
        .sel_o        (sel_comb)
    );

    // selects come only from the decode array
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sel_reg <= {NSEL{1'b0}};
        end
        else
        begin
            sel_reg <= sel_comb;
        end
    end

    assign primary_sector_selects_o   = sel_reg[15:0];
    assign secondary_sector_selects_o = sel_reg[19:16];
    assign sram_select_o              = sel_reg[20];
    assign ready_busy_output_o        = rb_reg;
    assign irq_o                      = irq_reg;
    assign wb_ack_o                   = ack_reg;
    assign wb_dat_o                   = dat_reg;
endmodule // mbs_top

// [verif/mbs_mcu_model.sv]
// mcu bus model driving address, space and strobe
// assumes selects come back one edge after the strobe
`timescale 1ns/1ps
module mbs_mcu_model #(
    parameter ADDR_W = 24
) (
    input  wire logic [0:0]        clk_i,
    input  wire logic [20:0]       sel_i,
    output logic      [ADDR_W-1:0] addr_o,
    output logic                   space_o,
    output logic                   strobe_o
);
    logic       go = 1'b0;
    logic [7:0] hi = 8'h0;
    logic       sp = 1'b0;
    initial addr_o = '0;
    initial space_o = 1'b0;
    initial strobe_o = 1'b0;
    // outside an access the lines wander so stale values never match
    always @(posedge clk_i)
    begin
        strobe_o <= go;
        space_o  <= go ? sp : ~space_o;
        addr_o   <= go ? {hi, {(ADDR_W-8){1'b0}}} : ~addr_o;
    end
    task automatic access(input logic [7:0] h, input logic s, output logic [20:0] hit);
        @(posedge clk_i);
        hi <= h;
        sp <= s;
        go <= 1'b1;
        repeat (3) @(posedge clk_i);
        hit = sel_i;
        go <= 1'b0;
    endtask
endmodule // mbs_mcu_model

// [verif/mbs_top_asserts.sv]
// concurrent checks on the ports of mbs_top
// assumes bind to mbs_top, one clock, synchronous reset
`timescale 1ns/1ps
`include "mbs_defs.vh"
module mbs_top_asserts #(
    parameter PROG_CYCLES  = 5,
    parameter ERASE_CYCLES = 20,
    parameter ADDR_W       = 24
) (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [7:0]        wb_adr_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic [ADDR_W-1:0] mcu_addr_i,
    input wire logic              mcu_prog_space_i,
    input wire logic              mcu_strobe_i,
    input wire logic [15:0]       primary_sector_selects_o,
    input wire logic [3:0]        secondary_sector_selects_o,
    input wire logic              sram_select_o,
    input wire logic              ready_busy_output_o,
    input wire logic              irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire        req     = wb_cyc_i & wb_stb_i;
    wire        rd_id0  = req & ~wb_we_i & (wb_adr_i == `MBS_ADR_ID0);
    wire        rd_id1  = req & ~wb_we_i & (wb_adr_i == `MBS_ADR_ID1);
    wire        cmd_req = req & wb_we_i & (wb_adr_i == `MBS_ADR_CMD);
    wire [20:0] any_sel = {sram_select_o, secondary_sector_selects_o, primary_sector_selects_o};
    logic [31:0] low_cnt;
    // length of the current busy stretch
    always_ff @(posedge clk_i)
        if (rst_i || ready_busy_output_o)
            low_cnt <= 32'h0;
        else
            low_cnt <= low_cnt + 32'h1;
    a_id0_value: assert property (rd_id0 && wb_ack_o |-> wb_dat_o == 32'h56)
        else $error("id0 read value wrong");
    a_id1_value: assert property (rd_id1 && wb_ack_o |-> wb_dat_o == 32'h03)
        else $error("id1 read value wrong");
    a_sel_needs_strobe: assert property (|any_sel |-> $past(mcu_strobe_i))
        else $error("select without mcu strobe");
    a_busy_cause: assert property (
        $fell(ready_busy_output_o) |-> $past(cmd_req) || $past(cmd_req, 2))
        else $error("busy without command");
    a_busy_bound: assert property (low_cnt <= ERASE_CYCLES + 1)
        else $error("busy too long");
    a_reset_ready: assert property (
        disable iff (1'b0) rst_i |=> ready_busy_output_o && !irq_o && !wb_ack_o)
        else $error("reset state wrong");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req))
        else $error("ack without request");
endmodule // mbs_top_asserts
bind mbs_top mbs_top_asserts #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES),
    .ADDR_W(ADDR_W)) i_mbs_top_asserts (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mcu_addr_i(mcu_addr_i),
    .mcu_prog_space_i(mcu_prog_space_i), .mcu_strobe_i(mcu_strobe_i),
    .primary_sector_selects_o(primary_sector_selects_o),
    .secondary_sector_selects_o(secondary_sector_selects_o), .sram_select_o(sram_select_o),
    .ready_busy_output_o(ready_busy_output_o), .irq_o(irq_o));

// [verif/mbs_top_tb.sv]
// self-checking bench for mbs_top
// assumes mcu model and checker bind compiled first
`timescale 1ns/1ps
`include "mbs_defs.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
    $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module mbs_top_tb;
    logic        clk_i, rst_i, cyc, stb, we, ack, rb, irq, mspace, mstb, rsel;
    logic [7:0]  adr;
    logic [31:0] dat, rdat, q;
    logic [3:0]  sel, bsel;
    logic [23:0] maddr;
    logic [15:0] fsel;
    logic [20:0] hit;
    int          error_cnt, n_tests;
    mbs_top #(.PROG_CYCLES(5), .ERASE_CYCLES(20), .ADDR_W(24)) i_mbs_top (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .mcu_addr_i(maddr),
        .mcu_prog_space_i(mspace), .mcu_strobe_i(mstb), .primary_sector_selects_o(fsel),
        .secondary_sector_selects_o(bsel), .sram_select_o(rsel), .ready_busy_output_o(rb),
        .irq_o(irq));
    mbs_mcu_model #(.ADDR_W(24)) i_mbs_mcu_model (.clk_i(clk_i), .sel_i({rsel, bsel, fsel}),
        .addr_o(maddr), .space_o(mspace), .strobe_o(mstb));
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            error_cnt++;
            $display("BAD %0t no ack", $time);
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic cmd_busy(input logic [31:0] c, input logic exp_rb);
        wb(1'b1, `MBS_ADR_CMD, c);
        @(posedge clk_i);
        `CHK(rb, exp_rb)
    endtask
    task automatic wait_rdy(input int lim);
        int n;
        n = 0;
        while (rb !== 1'b1 && n < lim)
        begin
            @(posedge clk_i);
            n++;
        end
        `CHK(rb, 1'b1)
    endtask
    task automatic t_ids;
        wb(1'b1, `MBS_ADR_ID0, 32'hff);
        wb(1'b1, `MBS_ADR_ID1, 32'hff);
        wb(1'b0, `MBS_ADR_ID0, 32'h0);
        `CHK(q, 32'h56)
        wb(1'b0, `MBS_ADR_ID1, 32'h0);
        `CHK(q, 32'h03)
        wb(1'b0, 8'h24, 32'h0);
        `CHK(q, 32'h0)
    endtask
    task automatic t_decode;
        for (int s = 0; s < 21; s++)
        begin
            wb(1'b1, `MBS_ADR_TERM_IDX, s * 3 + s % 3);
            wb(1'b1, `MBS_ADR_TERM_DATA, (s[0] ? 32'h5ff00 : 32'h3ff00) | s);
            i_mbs_mcu_model.access(s[7:0], ~s[0], hit);
            `CHK(hit, 21'h1 << s)
            i_mbs_mcu_model.access(s[7:0], s[0], hit);
            `CHK(hit, 21'h0)
        end
        repeat (3) @(posedge clk_i);
        `CHK({rsel, bsel, fsel}, 21'h0)
    endtask
    task automatic t_prog_irq;
        cmd_busy(32'h31, 1'b0);
        wb(1'b0, `MBS_ADR_STATUS, 32'h0);
        `CHK(q, 32'h1a)
        wait_rdy(10);
        wb(1'b0, `MBS_ADR_IRQ_STAT, 32'h0);
        `CHK(q[0], 1'b1)
        `CHK(irq, 1'b0)
        wb(1'b1, `MBS_ADR_IRQ_MASK, 32'h7);
        @(posedge clk_i);
        `CHK(irq, 1'b1)
        wb(1'b1, `MBS_ADR_IRQ_STAT, 32'h1);
        @(posedge clk_i);
        `CHK(irq, 1'b0)
    endtask
    task automatic t_erase_suspend;
        cmd_busy(32'h112, 1'b0);
        wb(1'b1, `MBS_ADR_CMD, 32'h22);
        wb(1'b0, `MBS_ADR_IRQ_STAT, 32'h0);
        `CHK(q[2], 1'b1)
        wb(1'b1, `MBS_ADR_IRQ_STAT, 32'h4);
        cmd_busy(32'h3, 1'b1);
        wb(1'b0, `MBS_ADR_STATUS, 32'h0);
        `CHK(q[2], 1'b1)
        i_mbs_mcu_model.access(8'd16, 1'b1, hit);
        `CHK(hit, 21'h10000)
        cmd_busy(32'h4, 1'b0);
        wait_rdy(25);
        wb(1'b0, `MBS_ADR_IRQ_STAT, 32'h0);
        `CHK(q[2:0], 3'h1)
        wb(1'b1, `MBS_ADR_IRQ_STAT, 32'h7);
    endtask
    task automatic t_protect;
        wb(1'b1, `MBS_ADR_PROT, 32'h20);
        cmd_busy(32'h52, 1'b1);
        wb(1'b0, `MBS_ADR_IRQ_STAT, 32'h0);
        `CHK(q[1], 1'b1)
        cmd_busy(32'h62, 1'b0);
        wait_rdy(25);
    endtask
    task automatic tally_and_finish;
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
    initial
    begin
        rst_i = 1'b1;
        {cyc, stb, we, adr, dat} = '0;
        sel = 4'hf;
        error_cnt = 0;
        n_tests = 0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        `CHK(rb, 1'b1)
        `CHK(irq, 1'b0)
        t_ids();
        t_decode();
        t_prog_irq();
        t_erase_suspend();
        t_protect();
        tally_and_finish();
    end
endmodule // mbs_top_tb
